// *** noise_filter.v ***
// two-flop synchroniser plus two-sample level filter with edge pulses
module noise_filter (
    input  wire hclk,       // system clock
    input  wire hresetn,    // async reset, active low
    input  wire pin_in,     // raw pin level
    input  wire sample_en,  // one-cycle sample strobe
    output reg  level_reg,  // filtered level
    output reg  rise_reg,   // one-cycle rising pulse
    output reg  fall_reg    // one-cycle falling pulse
);
    reg sync1_reg;
    reg sync2_reg;
    reg samp_reg;

    // synchroniser, first stage read only by second
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    // new level only after two equal samples
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            samp_reg  <= 1'b0;
            level_reg <= 1'b0;
            rise_reg  <= 1'b0;
            fall_reg  <= 1'b0;
        end else begin
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
            if (sample_en) begin
                samp_reg <= sync2_reg;
                if (samp_reg == sync2_reg && level_reg != sync2_reg) begin
                    level_reg <= sync2_reg;
                    rise_reg  <= sync2_reg;
                    fall_reg  <= ~sync2_reg;
                end
            end
        end
    end
endmodule

// *** pulse_source.sv ***
// pulse sources on the trigger pins and a load timing the square wave
module pulse_source (
    input  wire logic hclk,             // system clock
    output logic      trigger_input0,   // source 0
    output logic      trigger_input1,   // source 1, idles high
    input  wire logic timer_output_pin  // load
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_pin = 1'b0;
    int   since = 0;
    int   period = 0;
    initial begin
        trigger_input0 = 1'b0;
        trigger_input1 = 1'b1;
    end
    // change one source level just after an edge
    task automatic drive(input int ch, input logic v);
        @(posedge hclk);
        if (ch == 0) begin
            trigger_input0 <= v;
        end else begin
            trigger_input1 <= v;
        end
    endtask
    // cycles between the last two toggles of the load
    always @(posedge hclk) begin
        last_pin <= timer_output_pin;
        if (timer_output_pin !== last_pin) begin
            period <= since;
            since <= 1;
        end else begin
            since <= since + 1;
        end
    end
endmodule

// *** timer16.v ***
// 16-bit timer/event counter with captures, event count and square wave, AHB-Lite slave
`include "timer16_defs.vh"
module timer16 (
    input  wire        hclk,             // system clock, 100 MHz
    input  wire        hresetn,          // async reset, active low
    input  wire        hsel,             // slave select
    input  wire [31:0] haddr,            // byte address
    input  wire [1:0]  htrans,           // transfer type
    input  wire        hwrite,           // write when high
    input  wire [2:0]  hsize,            // transfer size
    input  wire [31:0] hwdata,           // write data
    input  wire        hready,           // bus ready
    output reg  [31:0] hrdata,           // read data
    output reg         hreadyout,        // slave ready
    output reg         hresp,            // response, always okay
    input  wire        trigger_input0,   // external trigger pin 0
    input  wire        trigger_input1,   // external trigger pin 1
    output reg         timer_output_pin, // square-wave output
    output reg         match_a_irq,      // compare a match / input1 capture a pulse
    output reg         match_b_irq       // capture b pulse
);
    // software-visible state, plus the toggle level and prescaler count that no read returns
    reg [15:0] counter16_reg;
    reg [15:0] cc_a_reg;
    reg [15:0] cc_b_reg;
    reg [1:0]  run_mode_reg;
    reg        overflow_reg;
    reg [2:0]  cc_ctrl_reg;
    reg [7:0]  prescaler_mode_reg;
    reg [1:0]  output_control_reg;
    reg        out_level_reg;
    reg [7:0]  prescale_reg;

    // bus data-phase state
    reg        wr_pend_reg;
    reg [7:0]  wr_addr_reg;

    // filtered trigger inputs
    wire       in0_rise;
    wire       in0_fall;
    wire       in1_rise;
    wire       in1_fall;

    // named fields
    wire [1:0] clock_select = prescaler_mode_reg[`PRM_CKS_HI:`PRM_CKS_LO];
    wire [1:0] input0_edge_select = prescaler_mode_reg[`PRM_ES0_HI:`PRM_ES0_LO];
    wire [1:0] input1_edge_select = prescaler_mode_reg[`PRM_ES1_HI:`PRM_ES1_LO];
    wire       running = (run_mode_reg != `RUN_STOP);
    wire       event_mode = (clock_select == `CKS_EVENT);

    // valid-edge decode shared by both inputs
    function edge_hit;
        input [1:0] sel;
        input       rise;
        input       fall;
        begin
            case (sel)
                `EDGE_FALL: edge_hit = fall;
                `EDGE_RISE: edge_hit = rise;
                `EDGE_BOTH: edge_hit = rise | fall;
                default:    edge_hit = 1'b0;
            endcase
        end
    endfunction

    // opposite-edge decode for the second capture of one input
    function edge_opposite;
        input [1:0] sel;
        input       rise;
        input       fall;
        begin
            case (sel)
                `EDGE_FALL: edge_opposite = rise;
                `EDGE_RISE: edge_opposite = fall;
                default:    edge_opposite = 1'b0;
            endcase
        end
    endfunction

    // prescaler runs only while the timer runs
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescale_reg <= 8'h00;
        end else if (!running) begin
            prescale_reg <= 8'h00;
        end else begin
            prescale_reg <= prescale_reg + 8'h01;
        end
    end

    // count clock strobe from the clock select bits
    reg count_tick;
    always @* begin
        case (clock_select)
            `CKS_DIV2:   count_tick = prescale_reg[0];
            `CKS_DIV4:   count_tick = ((prescale_reg & `PRE_DIV4_MASK) == `PRE_DIV4_MASK);
            `CKS_DIV256: count_tick = (prescale_reg == `PRE_DIV256_MASK);
            default:     count_tick = 1'b0;
        endcase
    end

    // event mode samples on system clock, capture modes on the count clock
    wire in0_sample = event_mode ? 1'b1 : count_tick;
    wire in1_sample = event_mode ? 1'b1 : count_tick;

    noise_filter u_filter0 (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_in    (trigger_input0),
        .sample_en (in0_sample),
        .level_reg (),
        .rise_reg  (in0_rise),
        .fall_reg  (in0_fall)
    );

    noise_filter u_filter1 (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_in    (trigger_input1),
        .sample_en (in1_sample),
        .level_reg (),
        .rise_reg  (in1_rise),
        .fall_reg  (in1_fall)
    );

    // edge events, only while running
    wire in0_valid = running & edge_hit(input0_edge_select, in0_rise, in0_fall);
    wire in0_back = running & edge_opposite(input0_edge_select, in0_rise, in0_fall);
    wire in1_valid = running & edge_hit(input1_edge_select, in1_rise, in1_fall);

    // counter advance: count clock, or a valid input0 edge in event mode
    wire advance = running & (event_mode ? in0_valid : count_tick);
    wire a_compare = ~cc_ctrl_reg[`CCC_A_CAPTURE];
    wire a_match = advance & a_compare & (counter16_reg == cc_a_reg);
    wire match_clear = a_match & (run_mode_reg == `RUN_MATCH_CLR);
    wire restart_hit = in0_valid & ~event_mode & (run_mode_reg == `RUN_RESTART);
    wire wrap = advance & (counter16_reg == `CNT_MAX) &
                (run_mode_reg != `RUN_MATCH_CLR);

    // capture strobes
    wire cap_b = in0_valid & ~event_mode & cc_ctrl_reg[`CCC_B_CAPTURE];
    wire cap_a_in1 = in1_valid & ~event_mode & cc_ctrl_reg[`CCC_A_CAPTURE] &
                     ~cc_ctrl_reg[`CCC_A_OPPOSITE];
    wire cap_a_back = in0_back & ~event_mode & cc_ctrl_reg[`CCC_A_CAPTURE] &
                      cc_ctrl_reg[`CCC_A_OPPOSITE];

    // overflow: wrap in free/restart, all-ones compare in match-clear
    wire ovf_set = wrap | (match_clear & (cc_a_reg == `CNT_MAX));

    // bus address phase accepted
    wire addr_ok = hsel & hready & htrans[1];

    // bus response: no wait states, always okay
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // address-phase latch for the write data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_reg <= haddr[7:0];
            end
        end
    end

    // read mux, unmapped offsets read zero
    reg [31:0] read_value;
    always @* begin
        read_value = 32'h0000_0000;
        case (haddr[7:0])
            `OFS_COUNTER:  read_value = {16'h0000, counter16_reg};
            `OFS_CC_A:     read_value = {16'h0000, cc_a_reg};
            `OFS_CC_B:     read_value = {16'h0000, cc_b_reg};
            `OFS_MODE:     read_value = {28'h0000000, run_mode_reg, 1'b0, overflow_reg};
            `OFS_CC_CTRL:  read_value = {29'h0000000, cc_ctrl_reg};
            `OFS_PRESCALE: read_value = {24'h000000, prescaler_mode_reg};
            `OFS_OUT_CTRL: read_value = {30'h0000000, output_control_reg};
            default:       read_value = 32'h0000_0000;
        endcase
    end

    // read data register, loaded in the read address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok & ~hwrite) begin
            hrdata <= read_value;
        end
    end

    // data-phase write decode, shared by every register but the read-only counter
    function wr_hit;
        input       pend;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            wr_hit = pend & (addr == ofs);
        end
    endfunction

    // data-phase write strobes
    wire wr_mode     = wr_hit(wr_pend_reg, wr_addr_reg, `OFS_MODE);
    wire wr_cc_a     = wr_hit(wr_pend_reg, wr_addr_reg, `OFS_CC_A);
    wire wr_cc_b     = wr_hit(wr_pend_reg, wr_addr_reg, `OFS_CC_B);
    wire wr_cc_ctrl  = wr_hit(wr_pend_reg, wr_addr_reg, `OFS_CC_CTRL);
    wire wr_prescale = wr_hit(wr_pend_reg, wr_addr_reg, `OFS_PRESCALE);
    wire wr_out_ctrl = wr_hit(wr_pend_reg, wr_addr_reg, `OFS_OUT_CTRL);

    // run mode: zero holds the counter, nonzero starts it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_mode_reg <= `RUN_STOP;
        end else if (wr_mode) begin
            run_mode_reg <= hwdata[`MODE_RUN_HI:`MODE_RUN_LO];
        end
    end

    // capture/compare roles of both registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cc_ctrl_reg <= 3'h0;
        end else if (wr_cc_ctrl) begin
            cc_ctrl_reg <= hwdata[2:0];
        end
    end

    // count clock and edge selects
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescaler_mode_reg <= `CTRL_RESET;
        end else if (wr_prescale) begin
            prescaler_mode_reg <= hwdata[7:0];
        end
    end

    // output enable and toggle bits
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_control_reg <= 2'h0;
        end else if (wr_out_ctrl) begin
            output_control_reg <= hwdata[1:0];
        end
    end

    // overflow flag: hardware set beats a software clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_reg <= 1'b0;
        end else if (ovf_set) begin
            overflow_reg <= 1'b1;
        end else if (wr_mode & ~hwdata[`MODE_OVF_BIT]) begin
            overflow_reg <= 1'b0;
        end
    end

    // next count: hold when stopped, clear on match or restart, else advance
    reg [15:0] counter_next;
    always @* begin
        counter_next = counter16_reg;
        if (!running) begin
            counter_next = counter16_reg;
        end else if (restart_hit | match_clear) begin
            counter_next = `CNT_RESET;
        end else if (advance) begin
            counter_next = counter16_reg + 16'h0001;
        end
    end

    // counter register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter16_reg <= `CNT_RESET;
        end else begin
            counter16_reg <= counter_next;
        end
    end

    // compare/capture register a: capture wins over a software write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cc_a_reg <= `CNT_RESET;
        end else if (cap_a_in1 | cap_a_back) begin
            cc_a_reg <= counter16_reg;
        end else if (wr_cc_a) begin
            cc_a_reg <= hwdata[15:0];
        end
    end

    // capture register b: capture wins over a software write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cc_b_reg <= `CNT_RESET;
        end else if (cap_b) begin
            cc_b_reg <= counter16_reg;
        end else if (wr_cc_b) begin
            cc_b_reg <= hwdata[15:0];
        end
    end

    // match a or input1 capture pulse, in the cycle a loads
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_a_irq <= 1'b0;
        end else begin
            match_a_irq <= a_match | cap_a_in1;
        end
    end

    // capture b pulse, in the cycle b loads
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_b_irq <= 1'b0;
        end else begin
            match_b_irq <= cap_b;
        end
    end

    // toggle state, cleared while disabled so enabling never makes an edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_level_reg <= 1'b0;
        end else if (!output_control_reg[`OUT_ENABLE_BIT]) begin
            out_level_reg <= 1'b0;
        end else if (a_match & output_control_reg[`OUT_TOGGLE_A_BIT]) begin
            out_level_reg <= ~out_level_reg;
        end
    end

    // square-wave pin, low while the output is disabled
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_output_pin <= 1'b0;
        end else begin
            timer_output_pin <= output_control_reg[`OUT_ENABLE_BIT] & out_level_reg;
        end
    end
endmodule

// *** timer16_defs.vh ***
// register map, field positions and reset values for the 16-bit timer
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH

// byte offsets of the word registers
`define OFS_COUNTER      8'h00
`define OFS_CC_A         8'h04
`define OFS_CC_B         8'h08
`define OFS_MODE         8'h0C
`define OFS_CC_CTRL      8'h10
`define OFS_PRESCALE     8'h14
`define OFS_OUT_CTRL     8'h18

// mode_control fields
`define MODE_OVF_BIT     0
`define MODE_RUN_LO      2
`define MODE_RUN_HI      3
`define RUN_STOP         2'h0
`define RUN_RESTART      2'h1
`define RUN_FREE         2'h2
`define RUN_MATCH_CLR    2'h3

// capture_compare_control fields
`define CCC_A_CAPTURE    0
`define CCC_A_OPPOSITE   1
`define CCC_B_CAPTURE    2

// prescaler_mode fields
`define PRM_CKS_LO       0
`define PRM_CKS_HI       1
`define PRM_ES0_LO       4
`define PRM_ES0_HI       5
`define PRM_ES1_LO       6
`define PRM_ES1_HI       7
`define CKS_DIV2         2'h0
`define CKS_DIV4         2'h1
`define CKS_DIV256       2'h2
`define CKS_EVENT        2'h3
`define EDGE_FALL        2'h0
`define EDGE_RISE        2'h1
`define EDGE_BOTH        2'h3

// output_control fields
`define OUT_ENABLE_BIT   0
`define OUT_TOGGLE_A_BIT 1

// reset values and limits
`define CNT_RESET        16'h0000
`define CNT_MAX          16'hFFFF
`define CTRL_RESET       8'h00
`define PRE_DIV4_MASK    8'h03
`define PRE_DIV256_MASK  8'hFF

`endif

// *** timer16_sva.sv ***
// concurrent checks on the timer ports
module timer16_sva (
    input wire logic        hclk,             // system clock
    input wire logic        hresetn,          // async reset, active low
    input wire logic        hsel,             // slave select
    input wire logic [1:0]  htrans,           // transfer type
    input wire logic        hwrite,           // write when high
    input wire logic        hready,           // bus ready
    input wire logic [31:0] hrdata,           // read data
    input wire logic        hreadyout,        // slave ready
    input wire logic        hresp,            // response
    input wire logic        timer_output_pin, // square-wave output
    input wire logic        match_a_irq,      // compare a / input1 capture a pulse
    input wire logic        match_b_irq       // capture b pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // zero wait states and okay response
    a_ready_high: assert property (hreadyout) else $error("slave not ready");
    a_resp_okay: assert property (!hresp) else $error("error response");
    // read data only moves after an accepted read
    a_rdata_holds: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_rdata_upper: assert property ((hsel && hready && htrans[1] && !hwrite) |=> hrdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    // interrupt requests are single-cycle pulses
    a_irqa_pulse: assert property (match_a_irq |=> !match_a_irq)
        else $error("irq a longer than one cycle");
    a_irqb_gap: assert property (match_b_irq |=> !match_b_irq [*3])
        else $error("captures b too close together");
    // output turns on only at a compare match
    a_pin_on_match: assert property ($rose(timer_output_pin) |-> match_a_irq || $past(match_a_irq))
        else $error("output rose without match");
    a_pin_spacing: assert property ($rose(timer_output_pin) |=> $stable(timer_output_pin) [*3])
        else $error("output toggled too soon");
endmodule

bind timer16 timer16_sva i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_output_pin(timer_output_pin), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));

// *** timer16_test.sv ***
// self-checking bench for the timer: bus tasks and mode scenarios
`include "timer16_defs.vh"
module timer16_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, trigger_input0, trigger_input1;
    logic        timer_output_pin, match_a_irq, match_b_irq;
    int          num_errors = 0;
    int          num_checks = 0;
    int          na = 0;
    int          nb = 0;

    timer16 i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .trigger_input0(trigger_input0),
        .trigger_input1(trigger_input1), .timer_output_pin(timer_output_pin),
        .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));
    pulse_source i_src (.hclk(hclk), .trigger_input0(trigger_input0), .trigger_input1(trigger_input1),
        .timer_output_pin(timer_output_pin));

    always #5 hclk = ~hclk;
    // count interrupt pulses
    always @(posedge hclk) begin
        if (match_a_irq === 1'b1) na <= na + 1;
        if (match_b_irq === 1'b1) nb <= nb + 1;
    end

    task automatic close_out();
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single ahb transfer, address phase then data phase
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk iff hreadyout);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk iff hreadyout);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic pulse0(input int hi, input int lo);
        i_src.drive(0, 1'b1);
        wait_cyc(hi);
        i_src.drive(0, 1'b0);
        wait_cyc(lo);
    endtask

    // watchdog against a hung bus or scenario
    initial begin
        wait_cyc(20000);
        num_errors++;
        close_out();
    end

    initial begin
        wait_cyc(2);
        hresetn <= 1'b1;
        // reset values, the last offset unmapped
        for (int i = 0; i < 8; i++) begin
            rchk(8'(i * 4), 32'h0);
        end
        // event counting on rising edges, compare a of 3
        wr(`OFS_CC_CTRL, 32'h0);
        wr(`OFS_PRESCALE, 32'h13);
        wr(`OFS_CC_A, 32'h3);
        wr(`OFS_MODE, 32'hC);
        repeat (3) pulse0(4, 4);
        rchk(`OFS_COUNTER, 32'h3);
        i_src.drive(0, 1'b1);
        i_src.drive(0, 1'b0);
        wait_cyc(6);
        rchk(`OFS_COUNTER, 32'h3);
        wr(`OFS_MODE, 32'h0);
        pulse0(4, 4);
        rchk(`OFS_COUNTER, 32'h3);
        wr(`OFS_MODE, 32'hC);
        pulse0(4, 6);
        rchk(`OFS_COUNTER, 32'h0);
        chk(na, 32'h1);
        wr(`OFS_COUNTER, 32'h55);
        rchk(`OFS_COUNTER, 32'h0);
        rchk(`OFS_MODE, 32'hC);
        // square wave, count clock hclk/2 with compare a of 4, toggling every 10 cycles
        wr(`OFS_MODE, 32'h0);
        wr(`OFS_PRESCALE, 32'h0);
        wr(`OFS_CC_CTRL, 32'h0);
        wr(`OFS_OUT_CTRL, 32'h3);
        wr(`OFS_CC_A, 32'h4);
        wr(`OFS_MODE, 32'hC);
        wait_cyc(40);
        chk(i_src.period, 32'hA);
        rchk(`OFS_MODE, 32'hC);
        wr(`OFS_MODE, 32'h0);
        wr(`OFS_OUT_CTRL, 32'h0);
        wait_cyc(2);
        chk(timer_output_pin, 32'h0);
        // free run, rise on input0 into b, fall on input1 into a
        na = 0;
        wr(`OFS_PRESCALE, 32'h10);
        wr(`OFS_CC_CTRL, 32'h5);
        wr(`OFS_MODE, 32'h8);
        i_src.drive(0, 1'b1);
        wait_cyc(39);
        i_src.drive(1, 1'b0);
        wait_cyc(10);
        xfer(1'b0, `OFS_CC_B, 32'h0);
        rchk(`OFS_CC_A, rd + 32'h14);
        chk(nb, 32'h1);
        chk(na, 32'h1);
        i_src.drive(0, 1'b0);
        i_src.drive(1, 1'b1);
        wait_cyc(10);
        // one input into two registers, opposite edge into a
        wr(`OFS_MODE, 32'h0);
        wr(`OFS_CC_CTRL, 32'h7);
        wr(`OFS_MODE, 32'h8);
        i_src.drive(0, 1'b1);
        wait_cyc(29);
        i_src.drive(0, 1'b0);
        wait_cyc(10);
        xfer(1'b0, `OFS_CC_B, 32'h0);
        rchk(`OFS_CC_A, rd + 32'hF);
        chk(nb, 32'h2);
        chk(na, 32'h1);
        // restart on both edges of input0
        wr(`OFS_MODE, 32'h0);
        wr(`OFS_PRESCALE, 32'h30);
        wr(`OFS_CC_CTRL, 32'h4);
        wr(`OFS_MODE, 32'h4);
        i_src.drive(0, 1'b1);
        wait_cyc(39);
        i_src.drive(0, 1'b0);
        wait_cyc(10);
        xfer(1'b0, `OFS_CC_B, 32'h0);
        chk(rd, 32'h14);
        chk(nb, 32'h4);
        // one-cycle glitch on input0 is shorter than two count-clock samples
        i_src.drive(0, 1'b1);
        i_src.drive(0, 1'b0);
        wait_cyc(10);
        chk(nb, 32'h4);
        close_out();
    end
endmodule
